// ---- common/sp_alu_pkg.sv ----
package sp_alu_pkg;

    // ****************************************************************
    // instruction encoding fields
    // ****************************************************************
    localparam int MAJOR_HI = 31;
    localparam int MAJOR_LO = 26;
    localparam logic [5:0] MAJOR_OPCODE_GROUP_A = 6'h00;
    localparam logic [5:0] MINOR_EXTENSION_GROUP = 6'h3C;
    localparam logic [9:0] ABS_QB_CODE = 10'h004;
    localparam logic [9:0] ABS_PH_CODE = 10'h044;
    localparam logic [9:0] ABS_W_CODE = 10'h084;
    localparam logic [10:0] WRAP_ADD_PH_CODE = 11'h00D;
    localparam logic [10:0] SAT_ADD_PH_CODE = 11'h40D;

    // ****************************************************************
    // register field positions
    // ****************************************************************
    localparam int FIELD_W = 5;
    localparam int F2125_LO = 21;
    localparam int F1620_LO = 16;
    localparam int F1115_LO = 11;

    // ****************************************************************
    // control register flag and saturation values
    // ****************************************************************
    localparam int OUFLAG_BIT = 20;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] H_MIN = 16'h8000;
    localparam logic [15:0] H_MAX = 16'h7FFF;
    localparam logic [7:0] B_MIN = 8'h80;
    localparam logic [7:0] B_MAX = 8'h7F;
    localparam logic [31:0] W_MIN = 32'h8000_0000;
    localparam logic [31:0] W_MAX = 32'h7FFF_FFFF;

    // ****************************************************************
    // operation kinds
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ABS_QB,
        OP_ABS_PH,
        OP_ABS_W,
        OP_ADD_PH,
        OP_ADDS_PH
    } op_t;

endpackage : sp_alu_pkg

// ---- common/sp_op_if.sv ----
// ****************************************************************
// decoded operation handed from decoder to top
// ****************************************************************
interface sp_op_if;
    sp_alu_pkg::op_t op;
    logic [4:0] dst;
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic reserved;
    modport dec (output op, output dst, output src_a, output src_b,
                 output reserved);
    modport use_side (input op, input dst, input src_a, input src_b,
                      input reserved);
endinterface : sp_op_if

// ---- src/sp_decode.sv ----
// ****************************************************************
// fixed encoding decoder
// ****************************************************************
module sp_decode (
    input wire logic [31:0] i_instr,
    sp_op_if.dec dec
);
    logic major_ok;
    logic [9:0] minor10;
    logic [10:0] minor11;

    // field extraction
    assign major_ok = i_instr[31:26] == sp_alu_pkg::MAJOR_OPCODE_GROUP_A;
    assign minor10 = i_instr[15:6];
    assign minor11 = i_instr[10:0];

    // opcode match and field placement per form
    always_comb begin
        dec.op = sp_alu_pkg::OP_NONE;
        dec.dst = i_instr[15:11];
        dec.src_a = i_instr[20:16];
        dec.src_b = i_instr[25:21];
        if (major_ok && i_instr[5:0] == sp_alu_pkg::MINOR_EXTENSION_GROUP)
        begin
            dec.dst = i_instr[25:21]; // RL2
            dec.src_a = i_instr[20:16];
            dec.src_b = 5'h00;
            case (minor10)
                sp_alu_pkg::ABS_PH_CODE: dec.op = sp_alu_pkg::OP_ABS_PH; // RL2
                sp_alu_pkg::ABS_QB_CODE: dec.op = sp_alu_pkg::OP_ABS_QB; // RL5
                sp_alu_pkg::ABS_W_CODE: dec.op = sp_alu_pkg::OP_ABS_W; // RL8
                default: dec.op = sp_alu_pkg::OP_NONE;
            endcase
        end else if (major_ok) begin
            case (minor11)
                sp_alu_pkg::WRAP_ADD_PH_CODE:
                    dec.op = sp_alu_pkg::OP_ADD_PH; // RL11
                sp_alu_pkg::SAT_ADD_PH_CODE:
                    dec.op = sp_alu_pkg::OP_ADDS_PH; // RL11
                default: dec.op = sp_alu_pkg::OP_NONE;
            endcase
        end
        dec.reserved = dec.op == sp_alu_pkg::OP_NONE;
    end
endmodule : sp_decode

// ---- src/sp_lane.sv ----
// ****************************************************************
// one halfword lane: saturating abs, wrapping add, saturating add
// ****************************************************************
module sp_lane (
    input wire logic [15:0] i_a,
    input wire logic [15:0] i_b,
    input wire logic i_add,
    input wire logic i_sat,
    output logic [15:0] o_abs,
    output logic o_abs_sat,
    output logic [15:0] o_sum,
    output logic o_ovf
);
    logic [16:0] sum17;

    // magnitude with clamp of the most negative value
    always_comb begin
        o_abs_sat = i_a == sp_alu_pkg::H_MIN;
        if (o_abs_sat)
            o_abs = sp_alu_pkg::H_MAX; // RL3
        else if (i_a[15])
            o_abs = 16'(-i_a); // RL3
        else
            o_abs = i_a;
    end

    // 17-bit sign-extended sum and overflow
    always_comb begin
        sum17 = {i_a[15], i_a} + {i_b[15], i_b};
        o_ovf = i_add && (sum17[16] != sum17[15]); // RL14
        if (i_sat && o_ovf)
            o_sum = sum17[16] ? sp_alu_pkg::H_MIN : sp_alu_pkg::H_MAX; // RL13
        else
            o_sum = sum17[15:0]; // RL12
    end
endmodule : sp_lane

// ---- src/sp_simd_alu.sv ----
// Summary of operation
// RL1: all five listed instruction forms are implemented
// RL2: halfword-pair abs decode and field placement
// RL3: halfword abs, 0x8000 clamps to 0x7FFF
// RL4: halfword abs saturation sets flag bit 20
// RL5: quad-byte abs decode, same fields
// RL6: byte abs, 0x80 clamps to 0x7F
// RL7: any byte saturation sets flag bit 20
// RL8: word abs decode
// RL9: word abs, most negative clamps to max
// RL10: word abs saturation sets flag bit 20
// RL11: halfword add decodes, wrap and saturating
// RL12: wrapping add truncates each sum
// RL13: saturating add clamps to 0x7FFF or 0x8000
// RL14: top two sum bits differ sets flag
// RL15: only reserved or disabled exceptions raised
// RL16: no operand-dependent exceptions
// RL17: flag is sticky, other bits untouched
module sp_simd_alu (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_issue,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_src_a,
    input wire logic [31:0] i_src_b,
    input wire logic i_sp_enable,
    input wire logic [31:0] i_ctrl,
    output logic o_valid,
    output logic [31:0] o_result,
    output logic [4:0] o_dst,
    output logic o_wr_en,
    output logic [31:0] o_ctrl,
    output logic o_ctrl_we,
    output logic o_exc_reserved,
    output logic o_exc_disabled
);
    // ****************************************************************
    // decode
    // ****************************************************************
    sp_op_if opi ();

    sp_decode u_dec (
        .i_instr(i_instr),
        .dec(opi)
    );

    // ****************************************************************
    // halfword lanes
    // ****************************************************************
    logic [31:0] abs_h;
    logic [31:0] sum_h;
    logic [1:0] abs_h_sat;
    logic [1:0] add_ovf;
    logic is_add;
    logic is_sat_add;

    assign is_add = opi.op == sp_alu_pkg::OP_ADD_PH ||
                    opi.op == sp_alu_pkg::OP_ADDS_PH;
    assign is_sat_add = opi.op == sp_alu_pkg::OP_ADDS_PH;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            sp_lane u_lane (
                .i_a(i_src_a[16*g +: 16]),
                .i_b(i_src_b[16*g +: 16]),
                .i_add(is_add),
                .i_sat(is_sat_add),
                .o_abs(abs_h[16*g +: 16]),
                .o_abs_sat(abs_h_sat[g]),
                .o_sum(sum_h[16*g +: 16]),
                .o_ovf(add_ovf[g])
            );
        end
    endgenerate

    // ****************************************************************
    // byte lanes
    // ****************************************************************
    logic [31:0] abs_b;
    logic [3:0] abs_b_sat;

    generate
        for (g = 0; g < 4; g++) begin : g_byte
            // byte magnitude with clamp
            always_comb begin
                abs_b_sat[g] = i_src_a[8*g +: 8] == sp_alu_pkg::B_MIN;
                if (abs_b_sat[g])
                    abs_b[8*g +: 8] = sp_alu_pkg::B_MAX; // RL6
                else if (i_src_a[8*g+7])
                    abs_b[8*g +: 8] = 8'(-i_src_a[8*g +: 8]); // RL6
                else
                    abs_b[8*g +: 8] = i_src_a[8*g +: 8];
            end
        end
    endgenerate

    // ****************************************************************
    // word magnitude
    // ****************************************************************
    logic [31:0] abs_w;
    logic abs_w_sat;

    // word magnitude with clamp
    always_comb begin
        abs_w_sat = i_src_a == sp_alu_pkg::W_MIN;
        if (abs_w_sat)
            abs_w = sp_alu_pkg::W_MAX; // RL9
        else if (i_src_a[31])
            abs_w = 32'(-i_src_a); // RL9
        else
            abs_w = i_src_a;
    end

    // ****************************************************************
    // result select and flag
    // ****************************************************************
    logic [31:0] result_nxt;
    logic flag_nxt;

    // choose result and saturation event by operation
    always_comb begin
        result_nxt = 32'h0000_0000;
        flag_nxt = 1'b0;
        case (opi.op) // RL1
            sp_alu_pkg::OP_ABS_PH: begin
                result_nxt = abs_h;
                flag_nxt = |abs_h_sat; // RL4
            end
            sp_alu_pkg::OP_ABS_QB: begin
                result_nxt = abs_b;
                flag_nxt = |abs_b_sat; // RL7
            end
            sp_alu_pkg::OP_ABS_W: begin
                result_nxt = abs_w;
                flag_nxt = abs_w_sat; // RL10
            end
            sp_alu_pkg::OP_ADD_PH, sp_alu_pkg::OP_ADDS_PH: begin
                result_nxt = sum_h;
                flag_nxt = |add_ovf; // RL14
            end
            default: begin
                result_nxt = 32'h0000_0000;
                flag_nxt = 1'b0;
            end
        endcase
    end

    logic go;
    assign go = i_issue && !opi.reserved && i_sp_enable;

    // ****************************************************************
    // output registers
    // ****************************************************************

    // result and destination
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_valid <= 1'b0;
            o_wr_en <= 1'b0;
            o_result <= 32'h0000_0000;
            o_dst <= 5'h00;
        end else begin
            o_valid <= i_issue;
            o_wr_en <= go;
            o_result <= go ? result_nxt : 32'h0000_0000;
            o_dst <= opi.dst;
        end
    end

    // control register update, flag set only
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_ctrl <= sp_alu_pkg::CTRL_RESET;
            o_ctrl_we <= 1'b0;
        end else begin
            o_ctrl <= i_ctrl; // RL17
            if (go && flag_nxt)
                o_ctrl[sp_alu_pkg::OUFLAG_BIT] <= 1'b1; // RL17
            o_ctrl_we <= go && flag_nxt;
        end
    end

    // exceptions depend only on encoding and enable, never on data
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_exc_reserved <= 1'b0;
            o_exc_disabled <= 1'b0;
        end else begin
            o_exc_reserved <= i_issue && opi.reserved; // RL15
            o_exc_disabled <= i_issue && !opi.reserved &&
                              !i_sp_enable; // RL16
        end
    end
endmodule : sp_simd_alu

// ---- test/sp_host_model.sv ----
// ****************************************************************
// host pipeline: holds the control register for the alu
// ****************************************************************
module sp_host_model #(
    parameter logic [31:0] INIT = 32'h0000_00A5
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [31:0] i_ctrl_new,
    input wire logic i_ctrl_we,
    output logic [31:0] o_ctrl
);
    // take the write-back only when the alu asks for it
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_ctrl <= INIT;
        end else if (i_ctrl_we) begin
            o_ctrl <= i_ctrl_new;
        end
    end
endmodule : sp_host_model

// ---- test/sp_simd_alu_assertions.sv ----
module sp_simd_alu_assertions (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_issue,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_src_a,
    input wire logic [31:0] i_src_b,
    input wire logic i_sp_enable,
    input wire logic [31:0] i_ctrl,
    input wire logic o_valid,
    input wire logic [31:0] o_result,
    input wire logic [4:0] o_dst,
    input wire logic o_wr_en,
    input wire logic [31:0] o_ctrl,
    input wire logic o_ctrl_we,
    input wire logic o_exc_reserved,
    input wire logic o_exc_disabled
);
    logic is_abs;
    logic is_w;
    logic is_add;
    logic go;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // ****************************************************************
    // decode of the five fixed encodings
    // ****************************************************************
    assign is_w = i_instr[15:6] == sp_alu_pkg::ABS_W_CODE;
    assign is_abs = i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h3C
        && (is_w || i_instr[15:6] == sp_alu_pkg::ABS_PH_CODE
        || i_instr[15:6] == sp_alu_pkg::ABS_QB_CODE);
    assign is_add = i_instr[31:26] == 6'h00 && (i_instr[9:0] == 10'h00D);
    assign go = i_issue && i_sp_enable;
    a_valid_after_issue: assert property (i_issue |=> o_valid)
        else $error("no valid after issue");
    a_idle_quiet: assert property (!i_issue |=> !o_valid && !o_ctrl_we)
        else $error("output without issue");
    a_abs_dst: assert property (go && is_abs |=> o_wr_en
        && o_dst == $past(i_instr[25:21])) else $error("abs dst wrong");
    a_word_clamp: assert property (go && is_abs && is_w
        && i_src_a == 32'h8000_0000 |=> o_result == 32'h7FFF_FFFF
        && o_ctrl_we) else $error("word clamp wrong");
    a_wrap_low_lane: assert property (go && is_add && !i_instr[10]
        |=> o_result[15:0] == $past(i_src_a[15:0]) + $past(i_src_b[15:0]))
        else $error("wrap sum wrong");
    a_add_dst: assert property (go && is_add
        |=> o_dst == $past(i_instr[15:11])) else $error("add dst wrong");
    a_no_data_exc: assert property (go && (is_abs || is_add)
        |=> !o_exc_reserved && !o_exc_disabled)
        else $error("data exception");
    a_disabled_exc: assert property (i_issue && !i_sp_enable &&
        (is_abs || is_add) |=> o_exc_disabled && !o_wr_en)
        else $error("disabled not flagged");
    a_reserved_exc: assert property (i_issue && !is_abs && !is_add
        |=> o_exc_reserved && !o_wr_en && !o_ctrl_we)
        else $error("reserved not flagged");
    a_ctrl_sticky: assert property (o_ctrl_we
        |-> o_ctrl == ($past(i_ctrl) | 32'h0010_0000))
        else $error("ctrl wrong");
    c_word_clamp: cover property (go && is_w && i_src_a == 32'h8000_0000);
    c_flag_write: cover property (o_ctrl_we);
    c_disabled: cover property (o_exc_disabled);
endmodule : sp_simd_alu_assertions

bind sp_simd_alu sp_simd_alu_assertions u_chk (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_issue(i_issue), .i_instr(i_instr),
    .i_src_a(i_src_a), .i_src_b(i_src_b), .i_sp_enable(i_sp_enable),
    .i_ctrl(i_ctrl), .o_valid(o_valid), .o_result(o_result), .o_dst(o_dst),
    .o_wr_en(o_wr_en), .o_ctrl(o_ctrl), .o_ctrl_we(o_ctrl_we),
    .o_exc_reserved(o_exc_reserved), .o_exc_disabled(o_exc_disabled));

// ---- test/saturating_abs_add_simd_alu_tb.sv ----
module saturating_abs_add_simd_alu_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_issue = 1'b0;
    logic i_sp_enable = 1'b1;
    logic [31:0] i_instr = 32'h0000_0000;
    logic [31:0] i_src_a = 32'h0000_0000;
    logic [31:0] i_src_b = 32'h0000_0000;
    logic [31:0] ctrl;
    logic o_valid, o_wr_en, o_ctrl_we, o_exc_reserved, o_exc_disabled;
    logic [31:0] o_result, o_ctrl;
    logic [4:0] o_dst;
    int err_count = 0;
    int checks = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    sp_simd_alu uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_issue(i_issue),
        .i_instr(i_instr), .i_src_a(i_src_a), .i_src_b(i_src_b),
        .i_sp_enable(i_sp_enable), .i_ctrl(ctrl), .o_valid(o_valid),
        .o_result(o_result), .o_dst(o_dst), .o_wr_en(o_wr_en), .o_ctrl(o_ctrl),
        .o_ctrl_we(o_ctrl_we), .o_exc_reserved(o_exc_reserved),
        .o_exc_disabled(o_exc_disabled));
    sp_host_model host_m (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_ctrl_new(o_ctrl), .i_ctrl_we(o_ctrl_we), .o_ctrl(ctrl));
    // ****************************************************************
    // shared helpers
    // ****************************************************************
    function automatic logic [31:0] ai(input logic [9:0] code);
        return {6'h00, 5'h03, 5'h04, code, 6'h3C};
    endfunction : ai
    function automatic logic [31:0] di(input logic [10:0] code);
        return {6'h00, 5'h05, 5'h06, 5'h07, code};
    endfunction : di
    task check(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask : check
    task close_out;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    // one issue cycle, outputs settled just after the answering edge
    task run(input logic [31:0] ins, a, b, input logic en);
        @(posedge i_sys_clk);
        i_issue <= 1'b1;
        i_instr <= ins;
        i_src_a <= a;
        i_src_b <= b;
        i_sp_enable <= en;
        @(posedge i_sys_clk);
        i_issue <= 1'b0;
        #1;
    endtask : run
    task op(input logic [31:0] ins, a, b, res, input logic flag);
        run(ins, a, b, 1'b1);
        check("valid", {o_valid, o_wr_en}, 32'h3);
        check("result", o_result, res);
        check("dst", o_dst,
            (ins[5:0] == 6'h3C) ? ins[25:21] : ins[15:11]);
        check("flag write", o_ctrl_we, flag);
        if (flag) check("ctrl", o_ctrl, ctrl | 32'h0010_0000);
        check("exceptions", {o_exc_reserved, o_exc_disabled}, 32'h0);
    endtask : op
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_abs;
        op(ai(sp_alu_pkg::ABS_PH_CODE), 32'h8000_FFFE, 32'h0,
            32'h7FFF_0002, 1'h1);
        op(ai(sp_alu_pkg::ABS_PH_CODE), 32'h7FFF_8001, 32'h0,
            32'h7FFF_7FFF, 1'h0);
        op(ai(sp_alu_pkg::ABS_QB_CODE), 32'h807F_FF00, 32'h0,
            32'h7F7F_0100, 1'h1);
        op(ai(sp_alu_pkg::ABS_QB_CODE), 32'h0102_FEFF, 32'h0,
            32'h0102_0201, 1'h0);
        op(ai(sp_alu_pkg::ABS_W_CODE), 32'h8000_0000, 32'h0,
            32'h7FFF_FFFF, 1'h1);
        op(ai(sp_alu_pkg::ABS_W_CODE), 32'hFFFF_FFFB, 32'h0,
            32'h0000_0005, 1'h0);
        $display("abs test done");
    endtask : t_abs
    task t_add;
        op(di(11'h00D), 32'h7FFF_0001, 32'h0001_FFFF, 32'h8000_0000, 1);
        op(di(11'h40D), 32'h7FFF_0001, 32'h0001_FFFF, 32'h7FFF_0000, 1);
        op(di(11'h40D), 32'h8000_0005, 32'hFFFF_0003, 32'h8000_0008, 1);
        op(di(11'h00D), 32'h0001_0002, 32'h0003_0004, 32'h0004_0006, 0);
        $display("add test done");
    endtask : t_add
    task t_exc;
        run(32'hFFFF_FFFF, 32'h8000_0000, 32'h0, 1'b1);
        check("reserved", {o_exc_reserved, o_wr_en, o_ctrl_we}, 32'h4);
        run(ai(sp_alu_pkg::ABS_W_CODE), 32'h8000_0000, 32'h0, 1'b0);
        check("disabled", {o_exc_disabled, o_wr_en, o_ctrl_we}, 32'h4);
        check("sticky ctrl", ctrl, 32'h0010_00A5);
        $display("exception test done");
    endtask : t_exc
    initial begin
        repeat (4) @(posedge i_sys_clk);
        check("reset quiet", {o_valid, o_wr_en, o_ctrl_we}, 32'h0);
        i_nrst <= 1'b1;
        t_abs();
        t_add();
        t_exc();
        close_out();
    end
    // cut a hang short
    initial begin
        #200000;
        err_count++;
        close_out();
    end
endmodule : saturating_abs_add_simd_alu_tb
